// ---- hdl/afrc_pkg.sv ----
// Package for the alarm, filter and rate configuration block.
// Assumes one 50 MHz system clock; the serial link is sampled, not clocked.
package afrc_pkg;
    // Byte addresses of the even (low) byte of each register
    localparam logic [6:0] ADDR_THR = 7'h32;
    localparam logic [6:0] ADDR_CTRL = 7'h34;
    localparam logic [6:0] ADDR_FILT = 7'h38;
    localparam logic [6:0] ADDR_DEC = 7'h3A;
    localparam logic [6:0] ADDR_DIAG = 7'h3C;
    localparam logic [6:0] ADDR_GCMD = 7'h3E;
    // Reset values and writable-bit masks
    localparam logic [15:0] RST_THR = 16'h0000;
    localparam logic [15:0] RST_CTRL = 16'h0080;
    localparam logic [15:0] RST_FILT = 16'h0000;
    localparam logic [15:0] RST_DEC = 16'h7421;
    localparam logic [15:0] MASK_CTRL = 16'h1FFC;
    localparam logic [15:0] MASK_FILT = 16'h0700;
    localparam logic [15:0] MASK_ALL = 16'hFFFF;
    // Alarm control and filter select field positions
    localparam int CTRL_NOCLR = 12;
    localparam int CTRL_DLY = 8;
    localparam int CTRL_LATCH = 7;
    localparam int CTRL_PINS = 6;
    localparam int CTRL_POL = 5;
    localparam int CTRL_SRC = 4;
    localparam int CTRL_SYS_EN = 3;
    localparam int CTRL_OUT_EN = 2;
    localparam int FILT_SEL = 8;
    // Diagnostic status and clear command positions
    localparam int DIAG_SYS = 14;
    localparam int DIAG_SPEC2 = 13;
    localparam int DIAG_SPEC1 = 10;
    localparam int DIAG_READY = 7;
    localparam logic [15:0] DIAG_ERR_MASK = 16'h007F;
    localparam int GCMD_CLR = 4;
    // Serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int FRAME_WR = 15;
    // Recording modes seen on the mode input
    localparam logic [1:0] MODE_RTS = 2'h0;
    localparam logic [1:0] MODE_MANUAL_FFT_MODE = 2'h1;
    localparam logic [1:0] MODE_AUTOMATIC_FFT_MODE = 2'h2;
    localparam logic [1:0] MODE_MTC = 2'h3;
    localparam logic [17:0] BASE_RATE = 18'h3_5B60;

    // Sample rate for a scale factor; zero where the factor is not legal
    function automatic logic [17:0] afrc_rate(input logic [3:0] f);
        if (f == 4'h0 || f > 4'h7) begin
            return 18'h0_0000;
        end
        return BASE_RATE >> f;
    endfunction : afrc_rate

    // FFT bin width in millihertz for a scale factor
    function automatic logic [15:0] afrc_bin_mhz(input logic [3:0] f);
        case (f)
            4'h1: return 16'hD228;
            4'h2: return 16'h6914;
            4'h3: return 16'h3458;
            4'h4: return 16'h1A36;
            4'h5: return 16'h0D16;
            4'h6: return 16'h0690;
            4'h7: return 16'h0347;
            default: return 16'h0000;
        endcase
    endfunction : afrc_bin_mhz
endpackage : afrc_pkg

// ---- hdl/afrc_sync.sv ----
// Two-flop synchroniser for the three serial input pins.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/1ns
module afrc_sync (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [2:0] pins_in,
    output logic [2:0] pins_out
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stable;
    } afrc_sync_st_t;

    afrc_sync_st_t st_reg;
    afrc_sync_st_t st_next;

    // First stage feeds only the second stage
    always_comb begin
        st_next.meta = pins_in;
        st_next.stable = st_reg.meta;
    end

    // Idle high: chip select and clock rest high
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= {3'b111, 3'b111};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins_out = st_reg.stable;
endmodule : afrc_sync

// ---- hdl/afrc_frame.sv ----
// Serial frame engine: 16-bit frames, clock idles high, data taken on
// the rising edge and changed on the falling edge. Inputs are synchronised.
`timescale 1ns/1ns
module afrc_frame (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sclk_s,
    input wire logic cs_b_s,
    input wire logic mosi_s,
    input wire logic [15:0] tx_word,
    output logic [15:0] rx_word,
    output logic frame_done,
    output logic miso
);
    typedef struct packed {
        logic sclk_d;
        logic cs_d;
        logic [4:0] cnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic miso;
        logic done;
    } afrc_frame_st_t;

    afrc_frame_st_t st_reg;
    afrc_frame_st_t st_next;

    // Edge detect, shift in, shift out, flag a whole frame
    always_comb begin
        st_next = st_reg;
        st_next.sclk_d = sclk_s;
        st_next.cs_d = cs_b_s;
        st_next.done = 1'b0;
        if (st_reg.cs_d && !cs_b_s) begin
            st_next.tx = tx_word;
            st_next.miso = tx_word[15];
            st_next.cnt = 5'h00;
        end else if (!cs_b_s && !st_reg.sclk_d && sclk_s) begin
            st_next.rx = {st_reg.rx[14:0], mosi_s};
            if (st_reg.cnt != 5'h1F) begin
                st_next.cnt = st_reg.cnt + 5'h01;
            end
        end else if (!cs_b_s && st_reg.sclk_d && !sclk_s && st_reg.cnt != 5'h00) begin
            st_next.tx = {st_reg.tx[14:0], 1'b0};
            st_next.miso = st_reg.tx[14];
        end
        // Frames of any other length are dropped
        if (!st_reg.cs_d && cs_b_s && st_reg.cnt == 5'(afrc_pkg::FRAME_BITS)) begin
            st_next.done = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= {1'b1, 1'b1, 5'h00, 16'h0000, 16'h0000, 1'b0, 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rx_word = st_reg.rx;
    assign frame_done = st_reg.done;
    assign miso = st_reg.miso;
endmodule : afrc_frame

// ---- hdl/afrc_top.sv ----
// Alarm, filter and rate configuration registers behind a serial port.
// Assumes measurements, error levels and mode come from clk_sys logic.
`timescale 1ns/1ns
module afrc_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    output logic miso,
    input wire logic [15:0] temp_meas,
    input wire logic [15:0] supply_meas,
    input wire logic [15:0] err_flags,
    input wire logic data_ready,
    input wire logic record_done,
    input wire logic spec_over1,
    input wire logic spec_over2,
    input wire logic [1:0] rate_sel,
    input wire logic [1:0] rec_mode,
    output logic first_alarm_pin,
    output logic second_alarm_pin,
    output logic [2:0] filter_select,
    output logic filter_bypass,
    output logic [17:0] sample_rate_sps,
    output logic [15:0] bin_width_mhz,
    output logic rate_apply
);
    typedef struct packed {
        logic [15:0] thr;
        logic [15:0] ctrl;
        logic [15:0] filt;
        logic [15:0] dec;
        logic [15:0] diag;
        logic [15:0] rd_data;
        logic [3:0] cnt1;
        logic [3:0] cnt2;
        logic pin1;
        logic pin2;
        logic [2:0] fsel;
        logic bypass;
        logic [17:0] rate;
        logic [15:0] bin;
        logic apply;
    } afrc_top_st_t;

    afrc_top_st_t st_reg;
    afrc_top_st_t st_next;
    logic [2:0] pins_s;
    logic [15:0] fr_word;
    logic fr_done;
    logic fr_miso;

    ////////////////////////////////////////////////////////////////////////
    // Serial link

    afrc_sync u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pins_in({sclk, cs_b, mosi}),
        .pins_out(pins_s)
    );

    afrc_frame u_frame (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sclk_s(pins_s[2]),
        .cs_b_s(pins_s[1]),
        .mosi_s(pins_s[0]),
        .tx_word(st_reg.rd_data),
        .rx_word(fr_word),
        .frame_done(fr_done),
        .miso(fr_miso)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register logic

    // Merge one byte into a register, keeping only writable bits
    function automatic logic [15:0] byte_put(input logic [15:0] old, input logic hi,
                                             input logic [7:0] d, input logic [15:0] msk);
        logic [15:0] v;
        v = hi ? {d, old[7:0]} : {old[15:8], d};
        return v & msk;
    endfunction : byte_put

    // Spectral record counter: next count and whether the flag sets
    function automatic logic [4:0] spec_step(input logic [3:0] cnt, input logic over,
                                             input logic [3:0] dly);
        logic [3:0] c;
        c = 4'h0;
        if (over) begin
            c = (cnt == 4'hF) ? cnt : cnt + 4'h1;
        end
        return {over && (cnt >= dly), c};
    endfunction : spec_step

    logic wr;
    logic hi;
    logic [6:0] addr;
    logic [6:0] waddr;
    logic [7:0] wdat;
    logic clr_cmd;
    logic stat_rd;
    logic [15:0] meas;
    logic sys_trip;
    logic [15:0] live;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [3:0] dly;
    logic [3:0] factor;

    // Decode the frame: write bit, address, data byte
    always_comb begin
        wr = fr_done && fr_word[afrc_pkg::FRAME_WR];
        addr = fr_word[14:8];
        waddr = {addr[6:1], 1'b0};
        hi = addr[0];
        wdat = fr_word[7:0];
        clr_cmd = wr && waddr == afrc_pkg::ADDR_GCMD && !hi && wdat[afrc_pkg::GCMD_CLR];
        stat_rd = fr_done && !fr_word[afrc_pkg::FRAME_WR] && waddr == afrc_pkg::ADDR_DIAG;
        dly = st_reg.ctrl[afrc_pkg::CTRL_DLY +: 4];
        factor = st_reg.dec[rate_sel * 4 +: 4];
    end

    // System alarm compare
    always_comb begin
        meas = st_reg.ctrl[afrc_pkg::CTRL_SRC] ? temp_meas : supply_meas;
        sys_trip = st_reg.ctrl[afrc_pkg::CTRL_POL] ? (meas < st_reg.thr)
                                                  : (meas > st_reg.thr);
        sys_trip = sys_trip && st_reg.ctrl[afrc_pkg::CTRL_SYS_EN];
        live = err_flags & afrc_pkg::DIAG_ERR_MASK;
        live[afrc_pkg::DIAG_SYS] = sys_trip;
        s1 = spec_step(st_reg.cnt1, spec_over1, dly);
        s2 = spec_step(st_reg.cnt2, spec_over2, dly);
    end

    // Next state of every register
    always_comb begin
        st_next = st_reg;
        // Byte writes to the configuration registers
        if (wr) begin
            unique case (waddr)
                afrc_pkg::ADDR_THR: begin
                    st_next.thr = byte_put(st_reg.thr, hi, wdat, afrc_pkg::MASK_ALL);
                end
                afrc_pkg::ADDR_CTRL: begin
                    st_next.ctrl = byte_put(st_reg.ctrl, hi, wdat, afrc_pkg::MASK_CTRL);
                end
                afrc_pkg::ADDR_FILT: begin
                    st_next.filt = byte_put(st_reg.filt, hi, wdat, afrc_pkg::MASK_FILT);
                end
                afrc_pkg::ADDR_DEC: begin
                    st_next.dec = byte_put(st_reg.dec, hi, wdat, afrc_pkg::MASK_ALL);
                end
                default: begin
                end
            endcase
        end
        // Error and system flags: sticky when latched, live otherwise; set wins
        if (st_reg.ctrl[afrc_pkg::CTRL_LATCH]) begin
            st_next.diag[6:0] = (clr_cmd ? 7'h00 : st_reg.diag[6:0]) | live[6:0];
            st_next.diag[14] = (!clr_cmd && st_reg.diag[14]) || live[14];
        end else begin
            st_next.diag[6:0] = live[6:0];
            st_next.diag[14] = live[14];
        end
        st_next.diag[afrc_pkg::DIAG_READY] = data_ready;
        // Spectral flags: cleared by command or by a status read unless held
        if (clr_cmd || (stat_rd && !st_reg.ctrl[afrc_pkg::CTRL_NOCLR])) begin
            st_next.diag[afrc_pkg::DIAG_SPEC1] = 1'b0;
            st_next.diag[afrc_pkg::DIAG_SPEC2] = 1'b0;
        end
        if (record_done) begin
            st_next.cnt1 = s1[3:0];
            st_next.cnt2 = s2[3:0];
            if (s1[4]) begin
                st_next.diag[afrc_pkg::DIAG_SPEC1] = 1'b1;
            end
            if (s2[4]) begin
                st_next.diag[afrc_pkg::DIAG_SPEC2] = 1'b1;
            end
        end
        st_next.diag[15] = 1'b0;
        st_next.diag[12:11] = 2'b00;
        st_next.diag[9:8] = 2'b00;
        // Read frame latches data returned in the next frame
        if (fr_done && !fr_word[afrc_pkg::FRAME_WR]) begin
            unique case (waddr)
                afrc_pkg::ADDR_THR: st_next.rd_data = st_reg.thr;
                afrc_pkg::ADDR_CTRL: st_next.rd_data = st_reg.ctrl;
                afrc_pkg::ADDR_FILT: st_next.rd_data = st_reg.filt;
                afrc_pkg::ADDR_DEC: st_next.rd_data = st_reg.dec;
                afrc_pkg::ADDR_DIAG: st_next.rd_data = st_reg.diag;
                default: st_next.rd_data = 16'h0000;
            endcase
        end
        // Alarm pins follow the spectral flags when routed and enabled
        st_next.pin1 = st_reg.ctrl[afrc_pkg::CTRL_PINS] && st_reg.ctrl[afrc_pkg::CTRL_OUT_EN]
                       && st_reg.diag[afrc_pkg::DIAG_SPEC1];
        st_next.pin2 = st_reg.ctrl[afrc_pkg::CTRL_PINS] && st_reg.ctrl[afrc_pkg::CTRL_OUT_EN]
                       && st_reg.diag[afrc_pkg::DIAG_SPEC2];
        // Filter and rate outputs
        st_next.fsel = st_reg.filt[afrc_pkg::FILT_SEL +: 3];
        st_next.bypass = st_reg.filt[afrc_pkg::FILT_SEL +: 3] == 3'b000;
        st_next.rate = afrc_pkg::afrc_rate(factor);
        st_next.bin = afrc_pkg::afrc_bin_mhz(factor);
        st_next.apply = rec_mode != afrc_pkg::MODE_RTS;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= {afrc_pkg::RST_THR, afrc_pkg::RST_CTRL, afrc_pkg::RST_FILT,
                       afrc_pkg::RST_DEC, 16'h0000, 16'h0000, 4'h0, 4'h0, 1'b0, 1'b0,
                       3'b000, 1'b1, 18'h0_0000, 16'h0000, 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign miso = fr_miso;
    assign first_alarm_pin = st_reg.pin1;
    assign second_alarm_pin = st_reg.pin2;
    assign filter_select = st_reg.fsel;
    assign filter_bypass = st_reg.bypass;
    assign sample_rate_sps = st_reg.rate;
    assign bin_width_mhz = st_reg.bin;
    assign rate_apply = st_reg.apply;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_thr_low;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr && waddr == afrc_pkg::ADDR_THR && !hi) |=> st_reg.thr[7:0] == $past(wdat);
    endproperty
    a_thr_low: assert property (p_thr_low) else $error("threshold byte not stored");

    property p_dec_keep;
        @(posedge clk_sys) disable iff (!rst_b)
        (wr && waddr == afrc_pkg::ADDR_DEC && hi) |=> st_reg.dec[7:0] == $past(st_reg.dec[7:0]);
    endproperty
    a_dec_keep: assert property (p_dec_keep) else $error("other byte changed");

    property p_reserved;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_reg.ctrl & ~afrc_pkg::MASK_CTRL) == 16'h0000
        && (st_reg.filt & ~afrc_pkg::MASK_FILT) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_bypass;
        @(posedge clk_sys) disable iff (!rst_b)
        ##1 filter_bypass == ($past(st_reg.filt) == afrc_pkg::RST_FILT);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass wrong");

    property p_latch;
        @(posedge clk_sys) disable iff (!rst_b)
        (st_reg.ctrl[afrc_pkg::CTRL_LATCH] && st_reg.diag[0] && !clr_cmd) |=> st_reg.diag[0];
    endproperty
    a_latch: assert property (p_latch) else $error("latched flag lost");

    property p_clear;
        @(posedge clk_sys) disable iff (!rst_b)
        (clr_cmd && live == 16'h0000 && !record_done)
        |=> st_reg.diag[14] == 1'b0 && st_reg.diag[6:0] == 7'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear command ignored");

    property p_noclr;
        @(posedge clk_sys) disable iff (!rst_b)
        (stat_rd && !clr_cmd && st_reg.ctrl[afrc_pkg::CTRL_NOCLR]
         && st_reg.diag[afrc_pkg::DIAG_SPEC1])
        |=> st_reg.diag[afrc_pkg::DIAG_SPEC1];
    endproperty
    a_noclr: assert property (p_noclr) else $error("spectral flag cleared on read");

    property p_delay;
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(st_reg.diag[afrc_pkg::DIAG_SPEC1])
        |-> $past(record_done && spec_over1 && st_reg.cnt1 >= dly);
    endproperty
    a_delay: assert property (p_delay) else $error("spectral flag early");

    property p_pins;
        @(posedge clk_sys) disable iff (!rst_b)
        first_alarm_pin
        |-> $past(st_reg.ctrl[afrc_pkg::CTRL_PINS] && st_reg.diag[afrc_pkg::DIAG_SPEC1]);
    endproperty
    a_pins: assert property (p_pins) else $error("alarm pin without cause");

    property p_sys;
        @(posedge clk_sys) disable iff (!rst_b)
        // Only the next cycle: an enable written now may raise the flag after that
        (!st_reg.ctrl[afrc_pkg::CTRL_LATCH] && !st_reg.ctrl[afrc_pkg::CTRL_SYS_EN])
        |=> !st_reg.diag[afrc_pkg::DIAG_SYS];
    endproperty
    a_sys: assert property (p_sys) else $error("system alarm while disabled");

    c_write: cover property (@(posedge clk_sys) disable iff (!rst_b) wr ##[1:200] wr);
    c_spec: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(first_alarm_pin));
    c_clear: cover property (@(posedge clk_sys) disable iff (!rst_b) clr_cmd && st_reg.diag != 16'h0000);
endmodule : afrc_top

// ---- tb/afrc_host.sv ----
// Host model: drives 16-bit serial frames into the configuration block.
// Assumes the caller starts each frame just after a clk_sys rising edge.
`timescale 1ns/1ns
module afrc_host (
    output logic sclk,
    output logic cs_b,
    output logic mosi,
    input wire logic miso
);
    // Link idles with clock high and no frame selected
    initial begin
        sclk = 1'b1;
        cs_b = 1'b1;
        mosi = 1'b0;
    end

    // One frame, MSB first: data changes on fall, read data taken on rise
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        cs_b = 1'b0;
        #80;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            mosi = w[i];
            #80;
            sclk = 1'b1;
            r[i] = miso;
            #80;
        end
        cs_b = 1'b1;
        mosi = ~mosi; // Released line shows no stale bit
        #160;
    endtask : xfer
endmodule : afrc_host

// ---- tb/tb_top.sv ----
// Testbench for the alarm, filter and rate configuration block.
// Assumes afrc_pkg is compiled first; host frames come from afrc_host.
`timescale 1ns/1ns
module tb_top;
    logic clk_sys, rst_b, sclk, cs_b, mosi, miso;
    logic [15:0] temp_meas, supply_meas, err_flags, dump, rd_val;
    logic data_ready, record_done, spec_over1, spec_over2;
    logic [1:0] rate_sel, rec_mode;
    logic first_alarm_pin, second_alarm_pin, filter_bypass, rate_apply;
    logic [2:0] filter_select;
    logic [17:0] sample_rate_sps;
    logic [15:0] bin_width_mhz;
    logic [3:0] f;
    int fails, total_checks;
    logic [15:0] bin_tab [8] = '{16'h0000, 16'hD228, 16'h6914, 16'h3458,
        16'h1A36, 16'h0D16, 16'h0690, 16'h0347};
    logic [7:0] sa_ctl [4] = '{8'h08, 8'h28, 8'h38, 8'h00};
    logic [15:0] sa_exp [4] = '{16'h4000, 16'h0000, 16'h4000, 16'h0000};

    afrc_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
        .mosi(mosi), .miso(miso), .temp_meas(temp_meas), .supply_meas(supply_meas),
        .err_flags(err_flags), .data_ready(data_ready), .record_done(record_done),
        .spec_over1(spec_over1), .spec_over2(spec_over2), .rate_sel(rate_sel),
        .rec_mode(rec_mode), .first_alarm_pin(first_alarm_pin),
        .second_alarm_pin(second_alarm_pin), .filter_select(filter_select),
        .filter_bypass(filter_bypass), .sample_rate_sps(sample_rate_sps),
        .bin_width_mhz(bin_width_mhz), .rate_apply(rate_apply));
    afrc_host host (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));

    ////////////////////////////////////////
    // Clock of 20 ns
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        if (seen !== exp) begin
            $display("MISMATCH %0t got %h expected %h", $time, seen, exp);
            fails++;
        end
        total_checks++;
    endtask : check

    task automatic tally_and_finish();
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : waitc

    task automatic wb(input logic [15:0] w);
        host.xfer(w, dump);
    endtask : wb

    // Full register write as two byte frames, low byte first
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        wb({1'b1, a, d[7:0]});
        wb({1'b1, a | 7'h01, d[15:8]});
    endtask : wr

    // Read: address frame, then data arrives in the following frame
    task automatic rd(input logic [6:0] a);
        wb({1'b0, a, 8'h00});
        host.xfer(16'h0000, rd_val);
    endtask : rd

    // One spectral record with the given band levels
    task automatic rec(input logic o1, input logic o2);
        spec_over1 = o1;
        spec_over2 = o2;
        record_done = 1'b1;
        waitc(1);
        record_done = 1'b0;
        waitc(3);
    endtask : rec

    ////////////////////////////////////////
    // Main test sequence
    initial begin
        {rst_b, data_ready, record_done, spec_over1, spec_over2} = '0;
        {temp_meas, supply_meas, err_flags} = '0;
        {rate_sel, rec_mode} = '0;
        repeat (12) @(posedge clk_sys);
        #2;
        rst_b = 1'b1;
        waitc(4);
        check(filter_bypass, 1'b1);
        check(sample_rate_sps, 18'h3_5B60 >> 1);
        check(bin_width_mhz, bin_tab[1]);
        check(rate_apply, 1'b0);
        rd(afrc_pkg::ADDR_THR);
        check(rd_val, 16'h0000);
        rd(afrc_pkg::ADDR_CTRL);
        check(rd_val, 16'h0080);
        rd(afrc_pkg::ADDR_FILT);
        check(rd_val, 16'h0000);
        rd(afrc_pkg::ADDR_DEC);
        check(rd_val, 16'h7421);
        rd(7'h40);
        check(rd_val, 16'h0000);
        wr(afrc_pkg::ADDR_THR, 16'hA5C3);
        rd(afrc_pkg::ADDR_THR);
        check(rd_val, 16'hA5C3);
        wr(afrc_pkg::ADDR_CTRL, 16'hFFFF);
        rd(afrc_pkg::ADDR_CTRL);
        check(rd_val, 16'h1FFC);
        wr(afrc_pkg::ADDR_CTRL, 16'h0000);
        // Two-frame filter load, low byte then high byte
        wb(16'hB871);
        wb(16'hB901);
        rd(afrc_pkg::ADDR_FILT);
        check(rd_val, 16'h0100);
        check(filter_bypass, 1'b0);
        for (int c = 0; c < 7; c++) begin
            wb({8'hB9, 5'h00, c[2:0]});
            check(filter_select, c[2:0]);
            check(filter_bypass, c == 0);
        end
        // Upper byte only changes two rate nibbles
        wb(16'hBB35);
        rd(afrc_pkg::ADDR_DEC);
        check(rd_val, 16'h3521);
        rec_mode = afrc_pkg::MODE_MANUAL_FFT_MODE;
        for (int s = 0; s < 4; s++) begin
            rate_sel = s[1:0];
            waitc(3);
            f = 4'(16'h3521 >> (4 * s));
            check(sample_rate_sps, 18'h3_5B60 >> f);
            check(bin_width_mhz, bin_tab[f]);
            check(rate_apply, 1'b1);
        end
        // End points of the scale factor on the last rate setting
        wb(16'hBB75);
        check(sample_rate_sps, 18'h3_5B60 >> 7);
        check(bin_width_mhz, 16'h0347);
        wb(16'hBB05);
        check(sample_rate_sps, 18'h0_0000);
        check(bin_width_mhz, 16'h0000);
        // Other recording modes
        rec_mode = afrc_pkg::MODE_AUTOMATIC_FFT_MODE;
        waitc(2);
        check(rate_apply, 1'b1);
        rec_mode = afrc_pkg::MODE_MTC;
        waitc(2);
        check(rate_apply, 1'b1);
        rec_mode = afrc_pkg::MODE_RTS;
        waitc(2);
        check(rate_apply, 1'b0);
        // System alarm: polarity, source and enable
        wr(afrc_pkg::ADDR_THR, 16'h1000);
        supply_meas = 16'h2000;
        temp_meas = 16'h0800;
        for (int k = 0; k < 4; k++) begin
            wb({8'hB4, sa_ctl[k]});
            rd(afrc_pkg::ADDR_DIAG);
            check(rd_val & 16'h4000, sa_exp[k]);
        end
        // Latched error flags and clear command
        wb(16'hB480);
        err_flags = 16'h0001;
        waitc(3);
        err_flags = 16'h0000;
        rd(afrc_pkg::ADDR_DIAG);
        check(rd_val[0], 1'b1);
        wb(16'hBE10);
        rd(afrc_pkg::ADDR_DIAG);
        check(rd_val[0], 1'b0);
        // Spectral alarms with a response delay of two records
        wr(afrc_pkg::ADDR_CTRL, 16'h0244);
        rec(1'b1, 1'b1);
        check({first_alarm_pin, second_alarm_pin}, 2'b00);
        rec(1'b1, 1'b1);
        rec(1'b1, 1'b1);
        check({first_alarm_pin, second_alarm_pin}, 2'b11);
        rd(afrc_pkg::ADDR_DIAG);
        check(rd_val & 16'h2400, 16'h2400);
        check({first_alarm_pin, second_alarm_pin}, 2'b00);
        wb(16'hB512);
        rec(1'b1, 1'b1);
        rec(1'b1, 1'b1);
        rec(1'b1, 1'b1);
        rd(afrc_pkg::ADDR_DIAG);
        check({first_alarm_pin, second_alarm_pin}, 2'b11);
        // Output alarm disabled: held flags no longer reach the pins
        wb(16'hB440);
        check({first_alarm_pin, second_alarm_pin}, 2'b00);
        tally_and_finish();
    end

    // Watchdog against a hung run
    initial begin
        #1000000;
        fails++;
        tally_and_finish();
    end
endmodule : tb_top
